// [tb/flash_cmd_ctrl_bench.sv]
/* Register-level bench for the flash command and status block.
   Assumes the bench itself stands in for the CPU, the array writes and the array engine. */
`timescale 1ns/100ps
`include "flash_cmd_map.vh"
module flash_cmd_ctrl_bench;
  reg sys_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [2:0] reg_addr_i = 3'h0;
  reg [7:0] reg_wdata_i = 8'h00;
  reg reg_wr_i = 1'b0, reg_rd_i = 1'b0, arr_wr_i = 1'b0, eng_done_i = 1'b0, eng_blank_i = 1'b0;
  reg [15:0] arr_addr_i = 16'h0000;
  reg [7:0] arr_wdata_i = 8'h00;
  reg irq_a;
  reg [15:0] exp_a = 16'h0000;
  wire [7:0] reg_rdata_o, eng_cmd_o, eng_data_o;
  wire [15:0] eng_addr_o;
  wire eng_start_o, irq_o;
  wire [1:0] security_state_code_o;
  integer mismatches = 0, samples_checked = 0, cycles = 0, lat = 6, cnt = 0, i;
  always #25 sys_clk_i = ~sys_clk_i;
  flash_cmd_ctrl #(.ADDR_W(16), .DATA_W(8)) u_flash_cmd_ctrl (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .arr_wr_i(arr_wr_i), .arr_addr_i(arr_addr_i), .arr_wdata_i(arr_wdata_i),
    .eng_start_o(eng_start_o), .eng_cmd_o(eng_cmd_o), .eng_addr_o(eng_addr_o), .eng_data_o(eng_data_o),
    .eng_done_i(eng_done_i), .eng_blank_i(eng_blank_i), .security_state_code_o(security_state_code_o),
    .irq_o(irq_o));
  // *****
  // Engine stand-in, busy for lat cycles
  // *****
  always @(posedge sys_clk_i) begin
    eng_done_i <= (cnt == 1);
    if (eng_start_o === 1'b1) cnt <= lat;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  task chk(input [7:0] got, input [7:0] exp, input [7:0] msk);
    begin
      samples_checked = samples_checked + 1;
      if ((got & msk) !== (exp & msk)) begin
        mismatches = mismatches + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, input [7:0] exp, input [7:0] msk);
    begin
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(reg_rdata_o, exp, msk);
    end
  endtask
  // data step, command step, launch step
  task seq(input [15:0] a, input [7:0] c);
    begin
      exp_a = a;
      @(posedge sys_clk_i);
      arr_wr_i <= 1'b1;
      arr_addr_i <= a;
      arr_wdata_i <= c ^ 8'h5a;
      @(posedge sys_clk_i);
      arr_wr_i <= 1'b0;
      wr(`OFS_COMMAND, c);
      wr(`OFS_STATUS, 8'h80);
    end
  endtask
  task wait_ev(input sel, input [7:0] c, input integer n);
    reg hit;
    integer k;
    begin
      hit = 1'b0;
      for (k = 0; k < n; k = k + 1) if (!hit) begin
        @(negedge sys_clk_i);
        hit = sel ? (eng_start_o === 1'b1) : (eng_done_i === 1'b1);
      end
      chk({7'h0, hit}, 8'h01, 8'hff);
      if (sel) begin
        chk(eng_cmd_o, c, 8'hff);
        chk(eng_data_o, c ^ 8'h5a, 8'hff);
        chk(eng_addr_o[15:8], exp_a[15:8], 8'hff);
        chk(eng_addr_o[7:0], exp_a[7:0], 8'hff);
      end else begin
        // Complete flag follows the idle engine by two edges
        repeat (2) @(posedge sys_clk_i);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(`OFS_STATUS, `STATUS_RST, 8'hff);
    rd(`OFS_SECURITY, {6'h0, `SEC_RESET}, 8'h03);
    rd(3'h6, 8'h00, 8'hff);
    seq(16'h0100, `CMD_BYTE_PROG);
    rd(`OFS_STATUS, 8'h10, 8'h10);
    wr(`OFS_STATUS, 8'h44);
    rd(`OFS_STATUS, 8'h50, 8'h54);
    wr(`OFS_STATUS, 8'h10);
    rd(`OFS_STATUS, 8'h00, 8'h10);
    wr(`OFS_CONFIG, 8'h01);
    for (i = 0; i < 3; i = i + 1) begin
      seq(16'h0100, (i == 0) ? 8'h00 : (i == 1) ? 8'h21 : 8'hff);
      rd(`OFS_STATUS, 8'h10, 8'h10);
      wr(`OFS_STATUS, 8'h10);
    end
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge sys_clk_i) eng_blank_i <= (i == 4);
      seq(16'h0100, (i == 0) ? `CMD_BYTE_PROG : (i == 1) ? `CMD_BURST_PROG : (i == 2) ? `CMD_PAGE_ERASE
        : (i == 3) ? `CMD_MASS_ERASE : `CMD_BLANK);
      wait_ev(1'b1, (i == 0) ? 8'h20 : (i == 1) ? 8'h25 : (i == 2) ? 8'h40 : (i == 3) ? 8'h41 : 8'h05, 6);
      rd(`OFS_STATUS, 8'h00, 8'h40);
      wait_ev(1'b0, 8'h00, 40);
      rd(`OFS_STATUS, 8'h40, 8'h50);
    end
    rd(`OFS_STATUS, 8'h04, 8'h04);
    rd(`OFS_SECURITY, {6'h0, `SEC_UNSECURED}, 8'h03);
    wr(`OFS_STATUS, 8'h04);
    rd(`OFS_STATUS, 8'h04, 8'h04);
    seq(16'h0100, `CMD_BYTE_PROG);
    wait_ev(1'b1, `CMD_BYTE_PROG, 6);
    rd(`OFS_STATUS, 8'h00, 8'h04);
    wait_ev(1'b0, 8'h00, 40);
    wr(`OFS_PROTECT, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      seq((i == 0) ? 16'h0400 : 16'h0100, (i == 0) ? `CMD_BYTE_PROG : `CMD_MASS_ERASE);
      rd(`OFS_STATUS, 8'h20, 8'h20);
      wr(`OFS_STATUS, 8'h00);
      rd(`OFS_STATUS, 8'h20, 8'h20);
      wr(`OFS_STATUS, 8'h20);
      rd(`OFS_STATUS, 8'h00, 8'h20);
    end
    // Mask polarity left open, so a change of irq, then irq low once all sources are cleared, is demanded
    wr(`OFS_IRQ_MASK, 8'h80);
    seq(16'h0100, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    irq_a = irq_o;
    wr(`OFS_IRQ_MASK, 8'h04);
    repeat (2) @(posedge sys_clk_i);
    chk({7'h0, irq_a ^ irq_o}, 8'h01, 8'hff);
    wr(`OFS_STATUS, 8'h30);
    wr(`OFS_IRQ_MASK, 8'h84);
    repeat (2) @(posedge sys_clk_i);
    chk({7'h0, irq_o}, 8'h00, 8'hff);
    lat = 20;
    seq(16'h0100, `CMD_BURST_PROG);
    wait_ev(1'b1, `CMD_BURST_PROG, 6);
    seq(16'h0101, `CMD_BURST_PROG);
    rd(`OFS_STATUS, 8'h00, 8'h80);
    wait_ev(1'b1, `CMD_BURST_PROG, 40);
    rd(`OFS_STATUS, 8'h80, 8'h80);
    seq(16'h0100, `CMD_BYTE_PROG);
    rd(`OFS_STATUS, 8'h10, 8'h10);
    wr(`OFS_STATUS, 8'h10);
    wait_ev(1'b0, 8'h00, 40);
    seq(16'h0100, `CMD_BYTE_PROG);
    wait_ev(1'b1, `CMD_BYTE_PROG, 6);
    wr(`OFS_CONFIG, 8'h05);
    rd(`OFS_STATUS, 8'h10, 8'h10);
    wr(`OFS_CONFIG, 8'h01);
    wr(`OFS_STATUS, 8'h10);
    wait_ev(1'b0, 8'h00, 40);
    seq(16'hffb0, `CMD_BYTE_PROG);
    rd(`OFS_STATUS, 8'h20, 8'h30);
    wr(`OFS_STATUS, 8'h20);
    wr(`OFS_CONFIG, 8'h03);
    seq(16'hffb0, `CMD_BYTE_PROG);
    rd(`OFS_STATUS, 8'h10, 8'h30);
    report_and_stop;
  end
endmodule
bind flash_cmd_ctrl flash_cmd_ctrl_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_flash_cmd_ctrl_sva (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .eng_start_o(eng_start_o),
  .eng_cmd_o(eng_cmd_o), .eng_addr_o(eng_addr_o), .eng_done_i(eng_done_i), .eng_blank_i(eng_blank_i),
  .security_state_code_o(security_state_code_o));

// [tb/flash_cmd_ctrl_sva.sv]
/* Port checker for the flash command and status block.
   Assumes it is bound to flash_cmd_ctrl and that the register map header is on the include path. */
`timescale 1ns/100ps
`include "flash_cmd_map.vh"
module flash_cmd_ctrl_sva #(parameter ADDR_W = 16, parameter DATA_W = 8) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [2:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire eng_start_o,
  input wire [7:0] eng_cmd_o,
  input wire [ADDR_W-1:0] eng_addr_o,
  input wire eng_done_i,
  input wire eng_blank_i,
  input wire [1:0] security_state_code_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire launch = reg_wr_i && reg_addr_i == `OFS_STATUS && reg_wdata_i[`ST_BUF_EMPTY];
  reg done_d1_ff;
  reg done_d2_ff;
  // Done history, one and two cycles back
  always @(posedge sys_clk_i) begin
    done_d1_ff <= eng_done_i;
    done_d2_ff <= done_d1_ff;
  end
  wire handoff = eng_cmd_o == `CMD_BURST_PROG && (done_d1_ff || done_d2_ff);
  // Read data stands only in the cycle after the strobe
  AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data not idle");
  AST_RDATA_UNMAPPED: assert property (reg_rd_i && reg_addr_i > 3'h5 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_STATUS_RSVD: assert property (reg_rd_i && reg_addr_i == `OFS_STATUS |=> reg_rdata_o[3] == 1'b0
    && reg_rdata_o[1:0] == 2'h0) else $error("reserved status bits set");
  AST_START_PULSE: assert property (eng_start_o |=> !eng_start_o) else $error("start longer than one cycle");
  AST_START_CAUSE: assert property (eng_start_o |-> $past(launch) || $past(launch, 2) || handoff)
    else $error("start without launch or handoff");
  AST_CMD_LEGAL: assert property (eng_start_o |-> eng_cmd_o inside {`CMD_BLANK, `CMD_BYTE_PROG,
    `CMD_BURST_PROG, `CMD_PAGE_ERASE, `CMD_MASS_ERASE}) else $error("illegal code reached engine");
  AST_ENG_HELD: assert property (!eng_start_o |-> $stable(eng_cmd_o) && $stable(eng_addr_o))
    else $error("engine command changed without start");
  AST_SEC_UNLOCK: assert property ($changed(security_state_code_o) |->
    security_state_code_o == `SEC_UNSECURED && ($past(eng_done_i && eng_blank_i) || $past(eng_done_i && eng_blank_i, 2)))
    else $error("security code changed without blank result");
  COV_START: cover property (eng_start_o);
  COV_HANDOFF: cover property (eng_start_o && handoff);
  COV_UNLOCK: cover property ($changed(security_state_code_o));
endmodule

// [verilog/flash_cmd_ctrl.v]
/*
 * Command launch, command buffer and status flags of the on-chip flash
 * controller, with a register port and a level interrupt.
 * Assumes an array engine that takes one command at a time, reports
 * done with a one-cycle pulse and, after a blank check, whether all
 * locations read erased.
 */
`timescale 1ns/100ps
`include "flash_cmd_map.vh"

// How it works
// RULE1 - Writing one to buffer-empty launches command
// RULE2 - Only burst program buffered; flag clears on handoff; code sets the buffer-empty flag on handoff
// RULE3 - Buffer-empty reads one when buffer accepts
// RULE4 - Complete set when idle, cleared on launch
// RULE5 - Writes to complete bit do nothing
// RULE6 - Protected target: ignore, set violation flag
// RULE7 - Violation flag cleared by writing one
// RULE8 - Bad sequence, no divider, stop: access error
// RULE9 - Access error cleared by one, zero ignored
// RULE10 - Blank flag set when array all erased
// RULE11 - Blank cleared on valid launch; writes ignored
// RULE12 - Status bits three, one, zero read zero
// RULE13 - Decode 0x05, 0x20, 0x25
// RULE14 - Decode page erase 0x40, mass 0x41
// RULE15 - Unknown code rejected with access error
// RULE16 - Successful blank check unsecures device
// RULE17 - Key window writes start command when locked; code drops them as data writes while key access is set
// RULE18 - Protected high block never programmed/erased
// RULE19 - Software orders data, command, launch
module flash_cmd_ctrl #(
  parameter ADDR_W = 16,
  parameter DATA_W = 8
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Register port
  input wire [2:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Array data writes from the CPU
  input wire arr_wr_i,
  input wire [ADDR_W-1:0] arr_addr_i,
  input wire [DATA_W-1:0] arr_wdata_i,
  // Array engine
  output reg eng_start_o,
  output reg [7:0] eng_cmd_o,
  output reg [ADDR_W-1:0] eng_addr_o,
  output reg [DATA_W-1:0] eng_data_o,
  input wire eng_done_i,
  input wire eng_blank_i,
  // Security and interrupt
  output reg [1:0] security_state_code_o,
  output reg irq_o
);

  // ****************************************
  // Sequence states
  // ****************************************
  localparam SEQ_IDLE = 2'h0;
  localparam SEQ_DATA = 2'h1;
  localparam SEQ_CMD = 2'h2;
  // Reset image of the status register, bits picked per flag
  localparam [7:0] STATUS_RST_V = `STATUS_RST;

  reg [1:0] seq_ff;
  reg [1:0] nxt_seq;
  reg [ADDR_W-1:0] q_addr_ff;
  reg [DATA_W-1:0] q_data_ff;
  reg [7:0] q_cmd_ff;
  reg [7:0] flash_command_ff;
  // Pending slot behind the one in the engine
  reg buf_full_ff;
  reg [ADDR_W-1:0] b_addr_ff;
  reg [DATA_W-1:0] b_data_ff;
  reg busy_ff;
  reg [7:0] run_cmd_ff;
  reg cmd_buffer_empty_flag_ff;
  reg cmd_complete_flag_ff;
  reg protect_violation_flag_ff;
  reg access_error_flag_ff;
  reg array_blank_flag_ff;
  reg [`IRQ_NUM-1:0] irq_mask_ff;
  reg [2:0] config_ff;
  reg [7:0] protect_ff;
  reg complete_d_ff;

  wire is_wr = reg_wr_i;
  wire wr_status = is_wr && reg_addr_i == `OFS_STATUS;
  wire wr_cmd = is_wr && reg_addr_i == `OFS_COMMAND;
  wire launch_wr = wr_status && reg_wdata_i[`ST_BUF_EMPTY];
  wire stop_req = config_ff[`CFG_STOP];
  wire div_set = config_ff[`CFG_DIV_SET];
  wire key_acc = config_ff[`CFG_KEY_ACC];
  wire protect_disable = protect_ff[0];
  wire [6:0] protect_boundary_select = protect_ff[7:1];

  // RULE17 key window
  wire in_key_win = arr_addr_i >= `KEY_LO && arr_addr_i <= `KEY_HI;
  wire data_wr = arr_wr_i && !(key_acc && in_key_win);

  // RULE13 RULE14 command decode
  wire cmd_known = q_cmd_ff == `CMD_BLANK || q_cmd_ff == `CMD_BYTE_PROG ||
    q_cmd_ff == `CMD_BURST_PROG || q_cmd_ff == `CMD_PAGE_ERASE || q_cmd_ff == `CMD_MASS_ERASE;
  wire cmd_modifies = q_cmd_ff != `CMD_BLANK;
  wire is_burst = q_cmd_ff == `CMD_BURST_PROG;

  // RULE18 protected block at high end, boundary in 512-byte steps
  wire [ADDR_W-1:0] prot_base = ({{(ADDR_W-7){1'b0}}, protect_boundary_select} << `PAGE_SHIFT) |
    {{(ADDR_W-`PAGE_SHIFT){1'b0}}, {`PAGE_SHIFT{1'b1}}};
  wire hits_prot = !protect_disable &&
    (q_cmd_ff == `CMD_MASS_ERASE || q_addr_ff > prot_base);

  // A launch is accepted only with the slot free and a whole sequence held
  wire can_take = cmd_buffer_empty_flag_ff;
  wire seq_ok = seq_ff == SEQ_CMD;
  // RULE2 only burst may queue behind a running command
  wire queue_ok = !busy_ff || (is_burst && run_cmd_ff == `CMD_BURST_PROG);
  // RULE8 RULE15 sequence, code, divider and stop checks
  wire acc_fail = !seq_ok || !cmd_known || (cmd_modifies && !div_set) || !queue_ok;
  wire good_launch = launch_wr && can_take && !acc_fail && !hits_prot;
  wire prot_fail = launch_wr && can_take && !acc_fail && hits_prot;
  wire stop_abort = stop_req && busy_ff;
  wire set_acc = (launch_wr && can_take && acc_fail) || stop_abort ||
    (wr_cmd && seq_ff != SEQ_DATA) || (data_wr && seq_ff == SEQ_CMD);

  // Handing the pending burst to the engine
  wire handoff = busy_ff && eng_done_i && buf_full_ff && !stop_abort;
  wire start_now = (good_launch && !busy_ff) || handoff;

  // ****************************************
  // Command sequence tracking
  // ****************************************
  // RULE19 expected order of writes
  always @* begin
    nxt_seq = seq_ff;
    case (seq_ff)
      SEQ_IDLE: begin
        if (data_wr) begin
          nxt_seq = SEQ_DATA;
        end
      end
      SEQ_DATA: begin
        if (wr_cmd) begin
          nxt_seq = SEQ_CMD;
        end
      end
      SEQ_CMD: begin
        if (launch_wr || data_wr) begin
          nxt_seq = SEQ_IDLE;
        end
      end
      default: begin
        nxt_seq = SEQ_IDLE;
      end
    endcase
    // Any error aborts the sequence
    if (set_acc) begin
      nxt_seq = SEQ_IDLE;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      seq_ff <= SEQ_IDLE;
      q_addr_ff <= {ADDR_W{1'b0}};
      q_data_ff <= {DATA_W{1'b0}};
      q_cmd_ff <= 8'h00;
      flash_command_ff <= 8'h00;
    end else begin
      seq_ff <= nxt_seq;
      if (data_wr && seq_ff == SEQ_IDLE) begin
        q_addr_ff <= arr_addr_i;
        q_data_ff <= arr_wdata_i;
      end
      if (wr_cmd) begin
        flash_command_ff <= reg_wdata_i;
        if (seq_ff == SEQ_DATA) begin
          q_cmd_ff <= reg_wdata_i;
        end
      end
    end
  end

  // ****************************************
  // Engine handoff and buffer
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
      buf_full_ff <= 1'b0;
      b_addr_ff <= {ADDR_W{1'b0}};
      b_data_ff <= {DATA_W{1'b0}};
      run_cmd_ff <= 8'h00;
      eng_start_o <= 1'b0;
      eng_cmd_o <= 8'h00;
      eng_addr_o <= {ADDR_W{1'b0}};
      eng_data_o <= {DATA_W{1'b0}};
    end else begin
      eng_start_o <= start_now;
      if (stop_abort) begin
        busy_ff <= 1'b0;
        buf_full_ff <= 1'b0;
      end else if (handoff) begin
        // RULE2 buffered burst goes to the array
        eng_addr_o <= b_addr_ff;
        eng_data_o <= b_data_ff;
        buf_full_ff <= 1'b0;
      end else if (good_launch && !busy_ff) begin
        // RULE1 launch straight into the engine
        busy_ff <= 1'b1;
        run_cmd_ff <= q_cmd_ff;
        eng_cmd_o <= q_cmd_ff;
        eng_addr_o <= q_addr_ff;
        eng_data_o <= q_data_ff;
      end else if (good_launch) begin
        buf_full_ff <= 1'b1;
        b_addr_ff <= q_addr_ff;
        b_data_ff <= q_data_ff;
      end else if (eng_done_i && busy_ff) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cmd_buffer_empty_flag_ff <= STATUS_RST_V[`ST_BUF_EMPTY];
      cmd_complete_flag_ff <= STATUS_RST_V[`ST_COMPLETE];
      protect_violation_flag_ff <= STATUS_RST_V[`ST_PROT_VIOL];
      access_error_flag_ff <= STATUS_RST_V[`ST_ACC_ERR];
      array_blank_flag_ff <= STATUS_RST_V[`ST_BLANK];
      security_state_code_o <= `SEC_RESET;
    end else begin
      // RULE3 empty while the pending slot is free
      if (good_launch && busy_ff) begin
        cmd_buffer_empty_flag_ff <= 1'b0;
      end else if (!buf_full_ff || handoff || stop_abort) begin
        cmd_buffer_empty_flag_ff <= 1'b1;
      end
      // RULE4 RULE5 hardware-only complete flag
      if (good_launch) begin
        cmd_complete_flag_ff <= 1'b0;
      end else if (!busy_ff && !buf_full_ff) begin
        cmd_complete_flag_ff <= 1'b1;
      end
      // RULE6 RULE7 set wins over clear
      if (prot_fail) begin
        protect_violation_flag_ff <= 1'b1;
      end else if (wr_status && reg_wdata_i[`ST_PROT_VIOL]) begin
        protect_violation_flag_ff <= 1'b0;
      end
      // RULE8 RULE9 set wins over clear
      if (set_acc) begin
        access_error_flag_ff <= 1'b1;
      end else if (wr_status && reg_wdata_i[`ST_ACC_ERR]) begin
        access_error_flag_ff <= 1'b0;
      end
      // RULE10 RULE11 blank flag
      if (good_launch && !busy_ff) begin
        array_blank_flag_ff <= 1'b0;
      end else if (busy_ff && eng_done_i && run_cmd_ff == `CMD_BLANK && eng_blank_i) begin
        array_blank_flag_ff <= 1'b1;
        // RULE16 unsecure after blank array
        security_state_code_o <= `SEC_UNSECURED;
      end
    end
  end

  // ****************************************
  // Software registers and interrupt
  // ****************************************
  wire [`IRQ_NUM-1:0] irq_src = {access_error_flag_ff, protect_violation_flag_ff, complete_d_ff};

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_mask_ff <= {`IRQ_NUM{1'b0}};
      config_ff <= 3'h0;
      protect_ff <= 8'hff;
      complete_d_ff <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      if (is_wr && reg_addr_i == `OFS_IRQ_MASK) begin
        irq_mask_ff <= reg_wdata_i[`IRQ_NUM-1:0];
      end
      if (is_wr && reg_addr_i == `OFS_CONFIG) begin
        // Divider-written flag is sticky once set
        config_ff <= {reg_wdata_i[`CFG_STOP], reg_wdata_i[`CFG_KEY_ACC],
          config_ff[`CFG_DIV_SET] | reg_wdata_i[`CFG_DIV_SET]};
      end
      // Protection boundary can only move down while enabled
      if (is_wr && reg_addr_i == `OFS_PROTECT && (protect_disable || reg_wdata_i[7:1] < protect_ff[7:1])) begin
        protect_ff <= reg_wdata_i;
      end
      // Complete event is sticky until written one
      if (!cmd_complete_flag_ff && !busy_ff && !buf_full_ff) begin
        complete_d_ff <= 1'b1;
      end else if (is_wr && reg_addr_i == `OFS_IRQ_MASK && reg_wdata_i[7]) begin
        complete_d_ff <= 1'b0;
      end
      irq_o <= |(irq_src & irq_mask_ff);
    end
  end

  // RULE12 reserved status bits read zero
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `OFS_STATUS: reg_rdata_o <= {cmd_buffer_empty_flag_ff, cmd_complete_flag_ff,
          protect_violation_flag_ff, access_error_flag_ff, 1'b0, array_blank_flag_ff, 2'h0};
        `OFS_COMMAND: reg_rdata_o <= flash_command_ff;
        `OFS_IRQ_MASK: reg_rdata_o <= {complete_d_ff, 4'h0, irq_mask_ff};
        `OFS_CONFIG: reg_rdata_o <= {5'h0, config_ff};
        `OFS_PROTECT: reg_rdata_o <= protect_ff;
        `OFS_SECURITY: reg_rdata_o <= {6'h0, security_state_code_o};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

// [verilog/flash_cmd_map.vh]
/*
 * Register offsets, field positions, command codes and reset values
 * for the flash command and status block.
 * Assumes inclusion by verilog/flash_cmd_ctrl.v and by the bench and its checker.
 */
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_STATUS 3'h0
`define OFS_COMMAND 3'h1
`define OFS_IRQ_MASK 3'h2
`define OFS_CONFIG 3'h3
`define OFS_PROTECT 3'h4
`define OFS_SECURITY 3'h5

// ****************************************
// Status fields
// ****************************************
`define ST_BUF_EMPTY 7
`define ST_COMPLETE 6
`define ST_PROT_VIOL 5
`define ST_ACC_ERR 4
`define ST_BLANK 2

// ****************************************
// Config fields
// ****************************************
`define CFG_DIV_SET 0
`define CFG_KEY_ACC 1
`define CFG_STOP 2

// ****************************************
// Interrupt sources
// ****************************************
`define IRQ_COMPLETE 0
`define IRQ_PROT_VIOL 1
`define IRQ_ACC_ERR 2
`define IRQ_NUM 3

// ****************************************
// Command codes
// ****************************************
`define CMD_BLANK 8'h05
`define CMD_BYTE_PROG 8'h20
`define CMD_BURST_PROG 8'h25
`define CMD_PAGE_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41

// ****************************************
// Constants
// ****************************************
`define ERASED_BYTE 8'hff
`define SEC_UNSECURED 2'h2
`define SEC_RESET 2'h0
`define KEY_LO 16'hffb0
`define KEY_HI 16'hffb7
`define PAGE_SHIFT 9
`define STATUS_RST 8'hc0

`endif
